// ---- hdl/pte_pkg.sv ----
// Constants, register map and types for the timing pulse and event capture core
package pte_pkg;
    // Clock and timing figures
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int CYC_PER_US = 1000 / CLK_NS;
    localparam int HALF_NS = CLK_NS / 2;
    localparam int EVT_RES_NS = 320;
    localparam int WIDTH_MIN_US = 10;
    localparam int WIDTH_MAX_US = 500_000;
    localparam logic [12:0] ADV_CYC = 13'h0800;
    localparam logic [8:0] PHASE_HALF = 9'h080;
    localparam logic [8:0] PHASE_FULL = 9'h100;
    localparam logic [8:0] ACC_STEP = 9'(CLK_NS);
    localparam logic [8:0] ACC_WRAP = 9'(EVT_RES_NS);
    // Satellite screening, survey and pulse width defaults
    localparam logic [3:0] MAX_SATS = 4'h8;
    localparam logic [3:0] FIX_SATS = 4'h4;
    localparam logic [15:0] SURVEY_DEF = 16'h07d0;
    localparam logic [7:0] ELEV_DEF = 8'h0a;
    localparam logic [7:0] SNR_DEF = 8'h04;
    localparam logic [7:0] DOP_DEF = 8'h08;
    localparam logic [3:0] MIN_SATS_DEF = 4'h1;
    localparam logic [19:0] WIDTH_DEF = 20'h0_0001;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OFFSET = 8'h04;
    localparam logic [7:0] REG_WIDTH = 8'h08;
    localparam logic [7:0] REG_MIN_SATS = 8'h0c;
    localparam logic [7:0] REG_SURVEY_LEN = 8'h10;
    localparam logic [7:0] REG_SURVEY_ALT = 8'h14;
    localparam logic [7:0] REG_MASKS = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [7:0] REG_QERR = 8'h20;
    localparam logic [7:0] REG_EVT_TAG = 8'h24;
    localparam logic [7:0] REG_EVT_CNT = 8'h28;
    // Control bit positions
    localparam int CTRL_PPS_EN = 0;
    localparam int CTRL_POL = 1;
    localparam int CTRL_UTC = 2;
    localparam int CTRL_SURVEY_EN = 3;
    localparam logic [3:0] CTRL_DEF = 4'h9;

    typedef enum logic [1:0] {
        PTE_ACQ = 2'h0,
        PTE_SURVEY = 2'h1,
        PTE_OVERDET = 2'h3
    } pte_mode_t;
endpackage : pte_pkg

// ---- hdl/pte_core.sv ----
// Timing pulse generator, event time tagger and start-up sequencer with APB registers
// How it works
// - Pulse leaves on the clock edge nearest the computed on-time mark.
// - Placement error never exceeds half a clock period.
// - Each pulse's quantization error is reported for host subtraction.
// - Host programs pulse width from 10 us to 500 ms.
// - Host sets pulse enable, polarity, GPS/UTC time base and signed offset.
// - Negative offset moves the pulse earlier than the mark.
// - Pulse withheld while satellites used (usable count capped at eight) fall below the host minimum.
// - Event capture fires only on a rising event input edge.
// - Event tags have 320 ns resolution, uncorrected for cable delay.
// - Each captured event tag is reported to the host.
// - Survey averages a fix count, 2000 default, then enters overdetermined mode.
// - Survey fix count writable through either of two registers.
// - After survey, time-only operation stops periodic navigation output.
// - During survey, data output stops below four conforming satellites.
// - Elevation mask, default ten degrees, screens low satellites.
// - Signal-to-noise mask defaults to four.
// - Dilution mask applies only while surveying or fixing position.
// - At most eight satellites feed the clock solution.
// - Overdetermined mode freezes position, solves clock, keeps pulse.
// - Status messages flow while acquiring satellites.
// - One pulse per second, leading edge on the selected second.
// - Event count increments per event, clears at reset, wraps after 65535.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module pte_core
    import pte_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic gps_mark_in,
    input wire logic [7:0] gps_phase_in,
    input wire logic utc_mark_in,
    input wire logic [7:0] utc_phase_in,
    input wire logic fix_in,
    input wire logic [4:0] sats_usable_in,
    input wire logic ephem_ok_in,
    input wire logic event_in,
    output logic pps_out,
    output logic qerr_report_out,
    output logic evt_report_out,
    output logic [7:0] elev_mask_out,
    output logic [7:0] snr_mask_out,
    output logic [7:0] dop_mask_out,
    output logic dop_mask_en_out,
    output logic [3:0] sats_used_out,
    output logic nav_out_en_out,
    output logic pos_update_en_out,
    output logic data_out_en_out,
    output logic status_out_en_out,
    output logic [1:0] mode_out
);
    typedef struct packed {
        pte_mode_t mode;
        logic [3:0] ctrl;
        logic [15:0] off_ns;
        logic [19:0] width_us;
        logic [3:0] min_sats;
        logic [15:0] survey_len;
        logic [7:0] elev;
        logic [7:0] snr;
        logic [7:0] dop;
        logic [15:0] fix_cnt;
        logic [3:0] sats_used;
        logic [12:0] dly_cnt;
        logic dly_run;
        logic [8:0] qerr_hold;
        logic [24:0] wid_cnt;
        logic pps_act;
        logic pps_pin;
        logic [8:0] qerr;
        logic qerr_strobe;
        logic [2:0] evt_sync;
        logic evt_stable;
        logic [8:0] tick_acc;
        logic [21:0] tag_cnt;
        logic [21:0] evt_tag;
        logic [15:0] evt_cnt;
        logic evt_pend;
        logic evt_strobe;
        logic nav_en;
        logic pos_en;
        logic data_en;
        logic dop_en;
        logic status_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pte_state_t;

    pte_state_t s;
    pte_state_t next_s;

    logic mark;
    logic [7:0] phase;
    logic [19:0] w_clamp;
    logic [24:0] width_cyc;
    logic signed [15:0] offs;
    logic [15:0] off_mag;
    logic [15:0] off_cyc;
    logic [12:0] base_dly;
    logic apb_acc;
    logic [31:0] rd_val;
    logic rd_err;

    always_comb begin
        next_s = s;
        next_s.qerr_strobe = 1'b0;
        next_s.evt_strobe = 1'b0;
        // Time base select between GPS and UTC marks
        mark = s.ctrl[CTRL_UTC] ? utc_mark_in : gps_mark_in;
        phase = s.ctrl[CTRL_UTC] ? utc_phase_in : gps_phase_in;
        // Width clamp keeps the pulse inside the legal range
        if (s.width_us < 20'(WIDTH_MIN_US)) begin
            w_clamp = 20'(WIDTH_MIN_US);
        end else if (s.width_us > 20'(WIDTH_MAX_US)) begin
            w_clamp = 20'(WIDTH_MAX_US);
        end else begin
            w_clamp = s.width_us;
        end
        width_cyc = 25'(w_clamp) * 25'(CYC_PER_US);
        // Offset rounded to nearest cycle, magnitude then sign
        offs = signed'(s.off_ns);
        off_mag = offs[15] ? 16'(-offs) : s.off_ns;
        off_cyc = 16'((17'(off_mag) + 17'(HALF_NS)) / 17'(CLK_NS));
        // Marks arrive ADV_CYC early so a negative offset can still advance
        base_dly = ADV_CYC + ((9'(phase) >= PHASE_HALF) ? 13'h0001 : 13'h0000);
        if (offs[15]) begin
            base_dly = base_dly - off_cyc[12:0];
        end else begin
            base_dly = base_dly + off_cyc[12:0];
        end

        // Satellite count capped for the clock solution
        next_s.sats_used = (sats_usable_in > 5'(MAX_SATS)) ? MAX_SATS
                                                          : sats_usable_in[3:0];

        // Start-up sequencer
        unique case (s.mode)
            PTE_ACQ: begin
                if (s.sats_used >= FIX_SATS && ephem_ok_in) begin
                    next_s.mode = PTE_SURVEY;
                    next_s.fix_cnt = 16'h0000;
                end
            end
            PTE_SURVEY: begin
                // With survey disabled the core stays in position fix mode
                if (fix_in && s.sats_used >= FIX_SATS && s.ctrl[CTRL_SURVEY_EN]) begin
                    next_s.fix_cnt = s.fix_cnt + 16'h0001;
                    if (s.fix_cnt + 16'h0001 >= s.survey_len) begin
                        next_s.mode = PTE_OVERDET;
                    end
                end
            end
            PTE_OVERDET: begin
                next_s.mode = PTE_OVERDET;
            end
        endcase
        next_s.nav_en = (next_s.mode != PTE_OVERDET);
        next_s.pos_en = (next_s.mode != PTE_OVERDET);
        next_s.dop_en = (next_s.mode == PTE_SURVEY);
        next_s.status_en = (next_s.mode == PTE_ACQ);
        next_s.data_en = !(next_s.mode == PTE_SURVEY && next_s.sats_used < FIX_SATS);

        // Pulse scheduling, one per mark
        if (mark) begin
            next_s.dly_cnt = base_dly;
            next_s.dly_run = 1'b1;
            if (9'(phase) < PHASE_HALF) begin
                next_s.qerr_hold = 9'(-$signed({1'b0, phase}));
            end else begin
                next_s.qerr_hold = PHASE_FULL - 9'(phase);
            end
        end else if (s.dly_run) begin
            if (s.dly_cnt == 13'h0001) begin
                next_s.dly_run = 1'b0;
                // Second boundary restarts the event tag counter
                next_s.tag_cnt = 22'h00_0000;
                next_s.tick_acc = 9'h000;
                next_s.qerr = s.qerr_hold;
                next_s.qerr_strobe = 1'b1;
                if (s.ctrl[CTRL_PPS_EN] && s.sats_used >= s.min_sats) begin
                    next_s.pps_act = 1'b1;
                    next_s.wid_cnt = width_cyc - 25'h000_0001;
                end
            end else begin
                next_s.dly_cnt = s.dly_cnt - 13'h0001;
            end
        end
        if (s.pps_act) begin
            if (s.wid_cnt == 25'h000_0000) begin
                next_s.pps_act = 1'b0;
            end else begin
                next_s.wid_cnt = s.wid_cnt - 25'h000_0001;
            end
        end
        next_s.pps_pin = next_s.pps_act ^ s.ctrl[CTRL_POL];

        // 320 ns tick from a fractional accumulator at 25 ns steps
        if (!(s.dly_run && s.dly_cnt == 13'h0001) || mark) begin
            if (s.tick_acc + ACC_STEP >= ACC_WRAP) begin
                next_s.tick_acc = s.tick_acc + ACC_STEP - ACC_WRAP;
                next_s.tag_cnt = s.tag_cnt + 22'h00_0001;
            end else begin
                next_s.tick_acc = s.tick_acc + ACC_STEP;
            end
        end

        // Event input: three stages, change accepted once stages two and three agree
        next_s.evt_sync = {s.evt_sync[1:0], event_in};
        if (s.evt_sync[1] == s.evt_sync[2]) begin
            next_s.evt_stable = s.evt_sync[2];
        end
        if (next_s.evt_stable && !s.evt_stable) begin
            next_s.evt_tag = s.tag_cnt;
            next_s.evt_cnt = s.evt_cnt + 16'h0001;
            next_s.evt_strobe = 1'b1;
        end

        // APB: pready one cycle into the access phase, effects at completion
        apb_acc = psel_in && penable_in && s.pready;
        rd_err = 1'b0;
        unique case (paddr_in)
            REG_CTRL: rd_val = {28'h000_0000, s.ctrl};
            REG_OFFSET: rd_val = {16'h0000, s.off_ns};
            REG_WIDTH: rd_val = {12'h000, s.width_us};
            REG_MIN_SATS: rd_val = {28'h000_0000, s.min_sats};
            REG_SURVEY_LEN, REG_SURVEY_ALT: rd_val = {16'h0000, s.survey_len};
            REG_MASKS: rd_val = {8'h00, s.dop, s.snr, s.elev};
            REG_STATUS: rd_val = {7'h00, s.fix_cnt, s.evt_pend, s.sats_used, 2'h0, s.mode};
            REG_QERR: rd_val = {{23{s.qerr[8]}}, s.qerr};
            REG_EVT_TAG: rd_val = {10'h000, s.evt_tag};
            REG_EVT_CNT: rd_val = {16'h0000, s.evt_cnt};
            default: begin
                rd_val = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
        next_s.pready = psel_in && penable_in && !s.pready;
        if (psel_in && penable_in && !s.pready) begin
            next_s.prdata = pwrite_in ? 32'h0000_0000 : rd_val;
            next_s.pslverr = rd_err;
        end else begin
            next_s.pslverr = 1'b0;
        end
        if (apb_acc && pwrite_in) begin
            unique case (paddr_in)
                REG_CTRL: next_s.ctrl = pwdata_in[3:0];
                REG_OFFSET: next_s.off_ns = pwdata_in[15:0];
                REG_WIDTH: next_s.width_us = pwdata_in[19:0];
                REG_MIN_SATS: next_s.min_sats = pwdata_in[3:0];
                REG_SURVEY_LEN, REG_SURVEY_ALT: next_s.survey_len = pwdata_in[15:0];
                REG_MASKS: begin
                    next_s.elev = pwdata_in[7:0];
                    next_s.snr = pwdata_in[15:8];
                    next_s.dop = pwdata_in[23:16];
                end
                default: next_s.ctrl = s.ctrl;
            endcase
        end
        // Pending flag: a new capture beats a clearing read
        if (next_s.evt_strobe) begin
            next_s.evt_pend = 1'b1;
        end else if (apb_acc && !pwrite_in && paddr_in == REG_EVT_CNT) begin
            next_s.evt_pend = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
            s.mode <= PTE_ACQ;
            s.ctrl <= CTRL_DEF;
            s.width_us <= WIDTH_DEF;
            s.min_sats <= MIN_SATS_DEF;
            s.survey_len <= SURVEY_DEF;
            s.elev <= ELEV_DEF;
            s.snr <= SNR_DEF;
            s.dop <= DOP_DEF;
            s.nav_en <= 1'b1;
            s.pos_en <= 1'b1;
            s.data_en <= 1'b1;
            s.status_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_out = s.prdata;
    assign pready_out = s.pready;
    assign pslverr_out = s.pslverr;
    assign pps_out = s.pps_pin;
    assign qerr_report_out = s.qerr_strobe;
    assign evt_report_out = s.evt_strobe;
    assign elev_mask_out = s.elev;
    assign snr_mask_out = s.snr;
    assign dop_mask_out = s.dop;
    assign dop_mask_en_out = s.dop_en;
    assign sats_used_out = s.sats_used;
    assign nav_out_en_out = s.nav_en;
    assign pos_update_en_out = s.pos_en;
    assign data_out_en_out = s.data_en;
    assign status_out_en_out = s.status_en;
    assign mode_out = s.mode;

    // Width checker counts active cycles of each pulse
    logic [24:0] chk_len;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chk_len <= 25'h000_0000;
        end else begin
            chk_len <= s.pps_act ? chk_len + 25'h000_0001 : 25'h000_0000;
        end
    end

    a_qerr_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $signed(s.qerr) <= 9'sd128 && $signed(s.qerr) >= -9'sd128)
        else $error("quantization error beyond half period");
    a_pps_withheld: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(s.pps_act) |-> $past(s.sats_used) >= $past(s.min_sats) && $past(s.ctrl[CTRL_PPS_EN]))
        else $error("pulse emitted without satellite criterion");
    a_pps_width: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(s.pps_act) |-> chk_len == width_cyc)
        else $error("pulse width differs from programmed width");
    a_pps_sched: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(s.pps_act) |-> $past(s.dly_run) && $past(s.dly_cnt) == 13'h0001 && s.qerr_strobe)
        else $error("pulse not on scheduled edge");
    a_evt_rising: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s.evt_strobe |-> s.evt_stable && !$past(s.evt_stable))
        else $error("event captured without rising edge");
    a_evt_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s.evt_strobe |-> s.evt_cnt == $past(s.evt_cnt) + 16'h0001 && s.evt_pend)
        else $error("event count not advanced");
    a_survey_end: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(s.mode == PTE_OVERDET) |-> s.fix_cnt >= s.survey_len && !s.nav_en && !s.pos_en)
        else $error("survey ended early or navigation still on");
    a_sats_cap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s.sats_used <= MAX_SATS)
        else $error("more than eight satellites used");
    a_data_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (s.mode == PTE_SURVEY && s.sats_used < FIX_SATS) |-> !s.data_en)
        else $error("data output during survey with too few satellites");
    a_apb_answer: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (psel_in && penable_in && !s.pready) |=> s.pready)
        else $error("APB answer late");
    a_pps_polarity: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s.pps_pin == (s.pps_act ^ $past(s.ctrl[CTRL_POL])))
        else $error("pulse pin polarity wrong");
    a_pps_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(s.pps_act) |-> !s.dly_run)
        else $error("pulse delay still running after leading edge");
    a_qerr_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s.qerr_strobe |=> !s.qerr_strobe)
        else $error("quantization report repeated");
    a_nav_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (s.mode == PTE_OVERDET) |-> !s.nav_en && !s.pos_en)
        else $error("navigation output in overdetermined mode");
    a_status_acq: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (s.mode == PTE_ACQ) == s.status_en)
        else $error("status output outside acquisition");
    a_dop_window: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (s.mode == PTE_SURVEY) == s.dop_en)
        else $error("dilution mask enable outside survey");
endmodule : pte_core

// ---- hdl/unused_placeholder_never.sv ----
// Intentionally empty design note file
`timescale 1ns/1ps

// ---- test/pte_host_model.sv ----
// Host equipment model: raises event edges, one at a time
`timescale 1ns/1ps
module pte_host_model (
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic report_in,
    output logic event_out
);
    int hold = 0;
    bit wait_rep = 1'b0;
    initial event_out = 1'b0;
    always @(posedge clk_in) begin
        // Next edge only after the previous tag came back
        if (report_in === 1'b1) begin
            wait_rep <= 1'b0;
        end
        if (hold > 0) begin
            hold <= hold - 1;
            event_out <= (hold > 1);
        end else if (req_in && !wait_rep) begin
            event_out <= 1'b1;
            hold <= 8;
            wait_rep <= 1'b1;
        end
    end
endmodule : pte_host_model

// ---- test/testbench.sv ----
// Self-checking bench for the timing pulse and event capture core
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %0t: got %0h exp %0h", $time, g, e); end end
module testbench;
    import pte_pkg::*;
    logic clk, rst_n, psel, pen, pwr, gmark, umark, fix, ephem, evt, req;
    logic [7:0] paddr, gph, uph, elev, snr, dop;
    logic [31:0] pwd, prdata, rd_d;
    logic [4:0] sats;
    logic [3:0] sats_used;
    logic [1:0] mode;
    logic pready, pslverr, pps, qrep, erep, dop_en, nav_en, pos_en, data_en, stat_en, rd_e;
    logic [31:0] mdl [logic [7:0]];
    logic [31:0] seed = 32'h0000_c82e;
    logic [8:0] q;
    logic [31:0] r;
    int n_mismatch = 0, total_checks = 0, n_qrep = 0, n_erep = 0, base, d, w, e, k;
    int off_ns [4] = '{0, -50, 63, -37};
    int off_cy [4] = '{0, -2, 3, -1};
    time t_pps, t_ev;

    pte_core uut (.clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .gps_mark_in(gmark),
        .gps_phase_in(gph), .utc_mark_in(umark), .utc_phase_in(uph), .fix_in(fix),
        .sats_usable_in(sats), .ephem_ok_in(ephem), .event_in(evt), .pps_out(pps),
        .qerr_report_out(qrep), .evt_report_out(erep), .elev_mask_out(elev),
        .snr_mask_out(snr), .dop_mask_out(dop), .dop_mask_en_out(dop_en),
        .sats_used_out(sats_used), .nav_out_en_out(nav_en), .pos_update_en_out(pos_en),
        .data_out_en_out(data_en), .status_out_en_out(stat_en), .mode_out(mode));
    pte_host_model host (.clk_in(clk), .req_in(req), .report_in(erep), .event_out(evt));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (qrep === 1'b1) n_qrep++;
        if (erep === 1'b1) n_erep++;
    end
    always @(posedge evt) t_ev = $time;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic apb(input logic wr_i, input logic [7:0] a, input logic [31:0] dd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= wr_i;
        paddr <= a;
        pwd <= dd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_d = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] dd);
        apb(1'b1, a, dd);
        mdl[a] = dd;
        if (a == REG_SURVEY_LEN || a == REG_SURVEY_ALT) begin
            mdl[REG_SURVEY_LEN] = dd;
            mdl[REG_SURVEY_ALT] = dd;
        end
    endtask : wr

    // Mark in, then cycles to the active level and how long it stays
    task automatic fire(input logic utc, input logic [7:0] ph);
        logic act;
        act = ~mdl[REG_CTRL][CTRL_POL];
        d = 0;
        w = 0;
        umark <= utc;
        gmark <= ~utc;
        uph <= ph;
        gph <= ph;
        @(posedge clk);
        umark <= 1'b0;
        gmark <= 1'b0;
        while (pps !== act && d < 3000) begin
            @(posedge clk);
            d++;
        end
        t_pps = $time;
        while (pps === act && w < 30000) begin
            @(posedge clk);
            w++;
        end
        if (d >= 3000) d = -1;
    endtask : fire

    task automatic results();
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial begin
        // Long enough for about two dozen pulses of 2.5k cycles
        #1_500_000;
        n_mismatch++;
        results();
    end

    initial begin
        {rst_n, psel, pen, pwr, gmark, umark, fix, ephem, req} = '0;
        {paddr, gph, uph, pwd, sats} = '0;
        mdl[REG_CTRL] = 32'(CTRL_DEF);
        mdl[REG_WIDTH] = 32'(WIDTH_DEF);
        mdl[REG_MIN_SATS] = 32'(MIN_SATS_DEF);
        mdl[REG_SURVEY_LEN] = 32'(SURVEY_DEF);
        mdl[REG_SURVEY_ALT] = 32'(SURVEY_DEF);
        mdl[REG_MASKS] = {8'h00, DOP_DEF, SNR_DEF, ELEV_DEF};
        repeat (4) @(posedge clk);
        `CHK(elev, ELEV_DEF)
        `CHK(snr, SNR_DEF)
        `CHK(dop, DOP_DEF)
        `CHK(stat_en, 1'b1)
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (mdl[a]) begin
            apb(1'b0, a, 32'h0000_0000);
            `CHK(rd_d, mdl[a])
        end
        apb(1'b0, 8'h30, 32'h0000_0000);
        `CHK(rd_e, 1'b1)
        wr(REG_SURVEY_ALT, 32'h0000_0003);
        apb(1'b0, REG_SURVEY_LEN, 32'h0000_0000);
        `CHK(rd_d, mdl[REG_SURVEY_LEN])
        wr(REG_MASKS, 32'h0006_030c);
        `CHK(elev, 8'h0c)
        `CHK(snr, 8'h03)
        `CHK(dop, 8'h06)
        $display("test registers done");
        ephem <= 1'b1;
        sats <= 5'h06;
        k = 0;
        while (mode !== PTE_SURVEY && k < 200) begin
            @(posedge clk);
            k++;
        end
        `CHK(mode, PTE_SURVEY)
        `CHK(dop_en, 1'b1)
        `CHK(stat_en, 1'b0)
        sats <= 5'h03;
        repeat (3) @(posedge clk);
        `CHK(data_en, 1'b0)
        sats <= 5'h0c;
        repeat (3) @(posedge clk);
        `CHK(sats_used, MAX_SATS)
        `CHK(data_en, 1'b1)
        repeat (3) begin
            fix <= 1'b1;
            @(posedge clk);
            fix <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (20) @(posedge clk);
        `CHK(mode, PTE_OVERDET)
        `CHK(nav_en, 1'b0)
        `CHK(pos_en, 1'b0)
        `CHK(dop_en, 1'b0)
        $display("test survey done");
        fire(1'b0, 8'h00);
        base = d;
        `CHK(1'(base >= 2048 && base <= 2050), 1'b1)
        `CHK(w, 10 * CYC_PER_US)
        wr(REG_WIDTH, 32'h0000_000c);
        for (int i = 0; i < 4; i++) begin
            r = xs();
            gph <= r[7:0];
            @(posedge clk);
            wr(REG_OFFSET, 32'(off_ns[i]));
            fire(1'b0, gph);
            `CHK(d, base + int'(gph >= 8'h80) + off_cy[i])
            `CHK(w, 12 * CYC_PER_US)
            q = (gph < 8'h80) ? 9'(-int'(gph)) : 9'(256 - int'(gph));
            apb(1'b0, REG_QERR, 32'h0000_0000);
            `CHK(rd_d[8:0], q)
            r = xs();
            repeat (50 + int'(r[7:0])) @(posedge clk);
            req <= 1'b1;
            k = 0;
            while (n_erep < i + 1 && k < 40) begin
                @(posedge clk);
                k++;
            end
            req <= 1'b0;
            e = int'((t_ev - t_pps) / EVT_RES_NS);
            apb(1'b0, REG_EVT_TAG, 32'h0000_0000);
            `CHK(1'(int'(rd_d[21:0]) >= e - 1 && int'(rd_d[21:0]) <= e + 1), 1'b1)
            apb(1'b0, REG_STATUS, 32'h0000_0000);
            `CHK(rd_d[8], 1'b1)
            `CHK(rd_d[7:4], MAX_SATS)
            apb(1'b0, REG_EVT_CNT, 32'h0000_0000);
            `CHK(rd_d, 32'(i + 1))
        end
        `CHK(n_erep, 4)
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        `CHK(rd_d[8], 1'b0)
        `CHK(rd_d[1:0], PTE_OVERDET)
        $display("test pulse and events done");
        wr(REG_OFFSET, 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_000b);
        repeat (2) @(posedge clk);
        `CHK(pps, 1'b1)
        fire(1'b0, 8'h00);
        `CHK(d, base)
        wr(REG_MIN_SATS, 32'h0000_0009);
        k = n_qrep;
        fire(1'b0, 8'h00);
        `CHK(d, -1)
        `CHK(n_qrep, k + 1)
        wr(REG_MIN_SATS, 32'h0000_0001);
        wr(REG_CTRL, 32'h0000_0008);
        fire(1'b0, 8'h00);
        `CHK(d, -1)
        wr(REG_CTRL, 32'h0000_000d);
        fire(1'b1, 8'h00);
        `CHK(d, base)
        fire(1'b0, 8'h00);
        `CHK(d, -1)
        $display("test pulse options done");
        results();
    end
endmodule : testbench
